// ### src/baud_tick.sv
// baud-rate tick generator
`timescale 1ns/10ps
module baud_tick (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [15:0] divisor,
  // tick out
  output logic tick
);
  logic [15:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r >= divisor) begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// ### src/bbp_pkg.sv
// constants, offsets and types of the bit-bang port
package bbp_pkg;
  // ==================== register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_BAUD = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ==================== field positions
  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_IFM_LSB = 4;
  localparam int CTRL_CHB_BIT = 6;
  localparam int CTRL_WAKE_BIT = 7;
  localparam int ST_ACTIVE_LSB = 0;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_RXVALID_BIT = 3;
  localparam int ST_EMPTY_BIT = 4;
  localparam int ST_FULL_BIT = 5;
  localparam int ST_RESUME_BIT = 6;
  localparam int ST_FLUSH_BIT = 7;
  // ==================== reset values and sizes
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0027;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  // ==================== mode command codes
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam logic [3:0] CMD_ASYNC = 4'h1;
  localparam logic [3:0] CMD_SYNC = 4'h4;
  // ==================== types
  typedef enum logic [1:0] {
    IFM_UART = 2'b00,
    IFM_FIFO = 2'b01,
    IFM_CPU_FIFO = 2'b10,
    IFM_FAST_OPTO = 2'b11
  } ifmode_t;
  typedef enum logic [1:0] {
    BB_OFF = 2'b00,
    BB_ASYNC = 2'b01,
    BB_SYNC = 2'b10
  } bbmode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WR_LOW = 3'b001,
    S_RD_DONE = 3'b010,
    S_SETUP = 3'b011,
    S_SWR_LOW = 3'b100
  } state_t;
endpackage

// ### src/bit_bang_port_with_strobes.sv
// bit-bang port of one channel with read and write strobes, apb registers
//
// Functional notes
// RULE1: bit-bang mode turns the channel's eight lines into a bidirectional byte bus.
// RULE2: per-line direction register; outputs drive latched byte, inputs only sampled.
// RULE3: asynchronous mode brings read and write strobes out on pins.
// RULE4: synchronous mode samples the data pins only while writing a byte.
// RULE5: fifo, cpu fifo or fast opto interface: strobes on the first pin pair.
// RULE6: uart interface: strobes on the second pin pair.
// RULE7: second channel refuses bit-bang while in fast opto serial mode.
// RULE8: suspended with wakeup enabled: low pulse on wake input requests resume.
// RULE9: awake: low pulse on wake input flushes pending transmit data.
// RULE10: mode command 1 selects asynchronous mode, 0 returns to reset.
// RULE11: mode command 4 selects synchronous mode.
// RULE12: synchronous mode samples pins before driving new byte; reads lag one byte.
// RULE13: asynchronous outputs change only on new byte and baud tick.
`timescale 1ns/10ps
module bit_bang_port_with_strobes
  import bbp_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit-bang data bus
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  // first strobe pair, fifo status otherwise
  output logic pair1_wr_n,
  output logic pair1_rd_n,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  // second strobe pair
  output logic pair2_wr_n,
  output logic pair2_rd_n,
  // suspend and send-now
  input wire logic power_enable_n,
  input wire logic send_now_wake_n,
  output logic resume_req,
  output logic flush_req
);
  // ==================== register state
  bbmode_t mode_r;
  ifmode_t ifm_r;
  logic chan_b_r;
  logic wake_en_r;
  logic refused_r;
  logic [7:0] dir_r;
  logic [15:0] baud_r;
  logic [7:0] rx_r;
  logic rx_valid_r;
  logic resume_seen_r;
  logic flush_seen_r;
  logic wake_prev_r;
  // engine
  state_t st_r;
  logic wr_n_r;
  logic rd_n_r;
  logic [7:0] out_r;
  logic tick;
  // fifo wires
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  logic [7:0] f_out_data;
  // bus decode
  logic acc;
  logic commit;
  logic wr_c;
  logic rd_c;
  logic mapped;
  logic tx_wait;
  logic [31:0] rd_mux;
  logic [3:0] cmd;
  logic opto_b;
  logic sample_now;
  logic wake_fall;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ==================== apb slave
  assign acc = psel & penable;
  assign commit = acc & pready;
  assign wr_c = commit & pwrite;
  assign rd_c = commit & ~pwrite;
  assign mapped = addr_is(paddr, OFF_CTRL) | addr_is(paddr, OFF_DIR) |
                  addr_is(paddr, OFF_BAUD) | addr_is(paddr, OFF_TXDATA) |
                  addr_is(paddr, OFF_RXDATA) | addr_is(paddr, OFF_STATUS);
  assign tx_wait = pwrite & addr_is(paddr, OFF_TXDATA) & ~f_in_ready;
  assign cmd = pwdata[CTRL_CMD_LSB +: 4];
  assign opto_b = pwdata[CTRL_CHB_BIT] &
                  (ifmode_t'(pwdata[CTRL_IFM_LSB +: 2]) == IFM_FAST_OPTO);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      addr_is(paddr, OFF_CTRL): begin
        rd_mux[CTRL_IFM_LSB +: 2] = ifm_r;
        rd_mux[CTRL_CHB_BIT] = chan_b_r;
        rd_mux[CTRL_WAKE_BIT] = wake_en_r;
        rd_mux[CTRL_CMD_LSB +: 4] = (mode_r == BB_ASYNC) ? CMD_ASYNC :
                                    (mode_r == BB_SYNC) ? CMD_SYNC : CMD_RESET;
      end
      addr_is(paddr, OFF_DIR): rd_mux[7:0] = dir_r;
      addr_is(paddr, OFF_BAUD): rd_mux[15:0] = baud_r;
      addr_is(paddr, OFF_RXDATA): rd_mux[7:0] = rx_r;
      addr_is(paddr, OFF_STATUS): begin
        rd_mux[ST_ACTIVE_LSB +: 2] = mode_r;
        rd_mux[ST_REFUSED_BIT] = refused_r;
        rd_mux[ST_RXVALID_BIT] = rx_valid_r;
        rd_mux[ST_EMPTY_BIT] = ~f_out_valid;
        rd_mux[ST_FULL_BIT] = ~f_in_ready;
        rd_mux[ST_RESUME_BIT] = resume_seen_r;
        rd_mux[ST_FLUSH_BIT] = flush_seen_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // answer on the second access cycle; txdata writes wait while the fifo is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready & ~tx_wait;
      prdata <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= acc & ~pready & ~tx_wait & ~mapped;
    end
  end

  // ==================== control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= BB_OFF;
      ifm_r <= IFM_UART;
      chan_b_r <= 1'b0;
      wake_en_r <= 1'b0;
      refused_r <= 1'b0;
      dir_r <= DIR_RST;
      baud_r <= BAUD_RST;
    end else if (wr_c) begin
      if (addr_is(paddr, OFF_CTRL)) begin
        ifm_r <= ifmode_t'(pwdata[CTRL_IFM_LSB +: 2]);
        chan_b_r <= pwdata[CTRL_CHB_BIT];
        wake_en_r <= pwdata[CTRL_WAKE_BIT];
        refused_r <= 1'b0;
        if (cmd == CMD_RESET) begin
          mode_r <= BB_OFF; // see RULE10
        end else if ((cmd == CMD_ASYNC || cmd == CMD_SYNC) && opto_b) begin
          mode_r <= BB_OFF; // see RULE7
          refused_r <= 1'b1;
        end else if (cmd == CMD_ASYNC) begin
          mode_r <= BB_ASYNC; // see RULE10
        end else if (cmd == CMD_SYNC) begin
          mode_r <= BB_SYNC; // see RULE11
        end
      end
      if (addr_is(paddr, OFF_DIR)) begin
        dir_r <= pwdata[7:0]; // see RULE2
      end
      if (addr_is(paddr, OFF_BAUD)) begin
        baud_r <= pwdata[15:0];
      end
    end
  end

  // ==================== transmit fifo and baud tick
  byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(wr_c & addr_is(paddr, OFF_TXDATA)),
    .in_ready(f_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data),
    .clear(mode_r == BB_OFF)
  );

  baud_tick u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(mode_r != BB_OFF),
    .divisor(baud_r),
    .tick(tick)
  );

  // ==================== bit-bang engine
  // sync mode needs room for the sample, so it waits on an unread byte
  assign f_pop = tick & f_out_valid & (st_r == S_IDLE) &
                 ((mode_r == BB_ASYNC) | ((mode_r == BB_SYNC) & ~rx_valid_r));
  assign sample_now = f_pop & (mode_r == BB_SYNC); // see RULE4

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      out_r <= 8'h00;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
    end else if (mode_r == BB_OFF) begin
      st_r <= S_IDLE;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
    end else if (tick) begin
      unique case (st_r)
        S_IDLE: begin
          if (f_pop && mode_r == BB_ASYNC) begin
            out_r <= f_out_data; // see RULE13
            wr_n_r <= 1'b0; // see RULE3
            st_r <= S_WR_LOW;
          end else if (sample_now) begin
            out_r <= f_out_data;
            rd_n_r <= 1'b0;
            st_r <= S_RD_DONE;
          end else if (mode_r == BB_ASYNC) begin
            rd_n_r <= 1'b0; // see RULE3
            st_r <= S_RD_DONE;
          end
        end
        S_WR_LOW: begin
          wr_n_r <= 1'b1;
          st_r <= S_IDLE;
        end
        S_RD_DONE: begin
          rd_n_r <= 1'b1;
          st_r <= (mode_r == BB_SYNC) ? S_SETUP : S_IDLE;
        end
        S_SETUP: begin
          rd_n_r <= 1'b0;
          st_r <= S_SWR_LOW;
        end
        S_SWR_LOW: begin
          wr_n_r <= 1'b0;
          st_r <= S_WR_LOW;
        end
      endcase
    end
  end

  // pins follow the latched byte; in sync mode the new byte appears after the sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 8'h00;
      data_oe <= 8'h00;
    end else begin
      data_oe <= (mode_r != BB_OFF) ? dir_r : 8'h00; // see RULE1
      if (mode_r == BB_ASYNC || (mode_r == BB_SYNC && st_r == S_SETUP && tick)) begin
        data_out <= out_r; // see RULE12
      end
    end
  end

  // ==================== read side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (sample_now) begin
      rx_r <= data_in; // see RULE12
      rx_valid_r <= 1'b1;
    end else if (mode_r == BB_ASYNC && tick && st_r == S_IDLE && !f_out_valid) begin
      rx_r <= data_in;
      rx_valid_r <= 1'b1;
    end else if ((rd_c && addr_is(paddr, OFF_RXDATA)) || mode_r == BB_OFF) begin
      rx_valid_r <= 1'b0; // see RULE10
    end
  end

  // ==================== strobe routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair1_wr_n <= 1'b1;
      pair1_rd_n <= 1'b1;
      pair2_wr_n <= 1'b1;
      pair2_rd_n <= 1'b1;
    end else if (mode_r != BB_OFF && ifm_r == IFM_UART) begin
      pair1_wr_n <= rx_avail_n;
      pair1_rd_n <= tx_space_n;
      pair2_wr_n <= wr_n_r; // see RULE6
      pair2_rd_n <= rd_n_r;
    end else if (mode_r != BB_OFF) begin
      pair1_wr_n <= wr_n_r; // see RULE5
      pair1_rd_n <= rd_n_r;
      pair2_wr_n <= 1'b1;
      pair2_rd_n <= 1'b1;
    end else begin
      pair1_wr_n <= rx_avail_n;
      pair1_rd_n <= tx_space_n;
      pair2_wr_n <= 1'b1;
      pair2_rd_n <= 1'b1;
    end
  end

  // ==================== send-now and wakeup
  assign wake_fall = wake_prev_r & ~send_now_wake_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_prev_r <= 1'b1;
      resume_req <= 1'b0;
      flush_req <= 1'b0;
      resume_seen_r <= 1'b0;
      flush_seen_r <= 1'b0;
    end else begin
      wake_prev_r <= send_now_wake_n;
      resume_req <= wake_fall & power_enable_n & wake_en_r; // see RULE8
      flush_req <= wake_fall & ~power_enable_n; // see RULE9
      if (wake_fall && power_enable_n && wake_en_r) begin
        resume_seen_r <= 1'b1;
      end else if (rd_c && addr_is(paddr, OFF_STATUS)) begin
        resume_seen_r <= 1'b0;
      end
      if (wake_fall && !power_enable_n) begin
        flush_seen_r <= 1'b1;
      end else if (rd_c && addr_is(paddr, OFF_STATUS)) begin
        flush_seen_r <= 1'b0;
      end
    end
  end
endmodule

// ### src/byte_fifo.sv
// parameterised first-word-fall-through fifo
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // housekeeping
  input wire logic clear
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (clear) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ### tb/bb_ext_logic.sv
// external logic clocked by the write strobes
`timescale 1ns/10ps
module bb_ext_logic (
  // clock and pins
  input wire logic pclk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic pair1_wr_n,
  input wire logic pair2_wr_n,
  input wire logic [7:0] ext_val,
  output logic [7:0] data_in,
  // what the far side latched
  output logic [7:0] got_byte,
  output logic [7:0] cnt1,
  output logic [7:0] cnt2
);
  logic w1_r = 1'b1;
  logic w2_r = 1'b1;
  // undriven lines show the far side's level, pulled up by default
  assign data_in = (data_out & data_oe) | (ext_val & ~data_oe);
  initial begin
    cnt1 = 8'h00;
    cnt2 = 8'h00;
    got_byte = 8'h00;
  end
  // latch on the trailing edge of either write strobe
  always @(posedge pclk) begin
    w1_r <= pair1_wr_n;
    w2_r <= pair2_wr_n;
    if ((!w1_r && pair1_wr_n) || (!w2_r && pair2_wr_n)) begin
      got_byte <= data_in;
    end
    if (!w1_r && pair1_wr_n) begin
      cnt1 <= cnt1 + 8'h01;
    end
    if (!w2_r && pair2_wr_n) begin
      cnt2 <= cnt2 + 8'h01;
    end
  end
endmodule

// ### tb/bit_bang_port_with_strobes_chk.sv
// assertions on the pins of the bit-bang port
`timescale 1ns/10ps
module bit_bang_port_with_strobes_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // pins
  input wire logic [7:0] data_out,
  input wire logic pair1_wr_n,
  input wire logic pair2_wr_n,
  input wire logic power_enable_n,
  input wire logic send_now_wake_n,
  input wire logic resume_req,
  input wire logic flush_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // bus answers
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready held");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata outside answer");
  property p_err_zero; pslverr |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
  // ==========
  // pins and wake
  property p_out_strobe; $changed(data_out) |-> ##[0:40] (!pair1_wr_n || !pair2_wr_n); endproperty
  a_out_strobe: assert property (p_out_strobe) else $error("byte without strobe");
  property p_flush_cause; $fell(send_now_wake_n) && !power_enable_n |-> ##[1:3] flush_req; endproperty
  a_flush_cause: assert property (p_flush_cause) else $error("no flush");
  property p_flush_awake; flush_req |-> !power_enable_n; endproperty
  a_flush_awake: assert property (p_flush_awake) else $error("flush in suspend");
  property p_resume_susp; resume_req |-> power_enable_n; endproperty
  a_resume_susp: assert property (p_resume_susp) else $error("resume while awake");
  property p_req_pulse; resume_req || flush_req |=> !(resume_req || flush_req); endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request not a pulse");
  c_flush: cover property (flush_req);
  c_resume: cover property (resume_req);
  c_pair2: cover property (!pair2_wr_n);
endmodule

bind bit_bang_port_with_strobes bit_bang_port_with_strobes_chk u_bit_bang_port_with_strobes_chk (
  .pclk, .presetn, .pready, .pslverr, .prdata, .data_out, .pair1_wr_n, .pair2_wr_n,
  .power_enable_n, .send_now_wake_n, .resume_req, .flush_req);

// ### tb/bit_bang_port_with_strobes_tb.sv
// testbench of the bit-bang port
`timescale 1ns/10ps
module bit_bang_port_with_strobes_tb;
  import bbp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, data_in, data_out, data_oe, ext_val, got_byte, cnt1, cnt2;
  logic [31:0] pwdata, prdata, rd;
  logic pair1_wr_n, pair1_rd_n, pair2_wr_n, pair2_rd_n;
  logic power_enable_n, send_now_wake_n, resume_req, flush_req;
  logic rx_avail_n, tx_space_n;
  int n_errors, checks;
  bit_bang_port_with_strobes u_bit_bang_port_with_strobes (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .data_in, .data_out, .data_oe,
    .pair1_wr_n, .pair1_rd_n, .rx_avail_n, .tx_space_n, .pair2_wr_n,
    .pair2_rd_n, .power_enable_n, .send_now_wake_n, .resume_req, .flush_req);
  bb_ext_logic u_bb_ext_logic (.pclk, .data_out, .data_oe, .pair1_wr_n, .pair2_wr_n,
    .ext_val, .data_in, .got_byte, .cnt1, .cnt2);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_done;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    apb(1'b0, OFF_DIR, 32'h0);
    chk("dir", {24'h0, DIR_RST}, rd);
    apb(1'b0, OFF_BAUD, 32'h0);
    chk("baud", {16'h0, BAUD_RST}, rd);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", 32'h10, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    rx_avail_n <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pair1 status wr", 32'h0, {31'h0, pair1_wr_n});
    chk("pair1 status rd", 32'h1, {31'h0, pair1_rd_n});
    rx_avail_n <= 1'b1;
    tx_space_n <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pair1 status wr", 32'h1, {31'h0, pair1_wr_n});
    chk("pair1 status rd", 32'h0, {31'h0, pair1_rd_n});
    tx_space_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_async(input logic [1:0] ifm, input logic [7:0] b, input logic [7:0] dir);
    logic [7:0] c1;
    logic [7:0] c2;
    int n;
    apb(1'b1, OFF_DIR, {24'h0, dir});
    apb(1'b1, OFF_CTRL, {24'h0, 2'b00, ifm, CMD_ASYNC});
    c1 = cnt1;
    c2 = cnt2;
    n = 0;
    apb(1'b1, OFF_TXDATA, {24'h0, b});
    while (cnt1 === c1 && cnt2 === c2 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("far byte", {24'h0, (b & dir) | ~dir}, {24'h0, got_byte});
    chk("oe", {24'h0, dir}, {24'h0, data_oe});
    chk("pair1", {31'h0, ifm != IFM_UART}, {24'h0, cnt1 - c1});
    chk("pair2", {31'h0, ifm == IFM_UART}, {24'h0, cnt2 - c2});
    n = 0;
    while (((ifm == IFM_UART) ? pair2_rd_n : pair1_rd_n) !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("async rd strobe", 32'h0, {31'h0, ((ifm == IFM_UART) ? pair2_rd_n : pair1_rd_n)});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("mode", 32'h1, {30'h0, rd[1:0]});
  endtask
  task automatic t_sync;
    logic [7:0] b [9];
    int n;
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_DIR, 32'hFF);
    apb(1'b1, OFF_CTRL, {24'h0, 2'b00, IFM_FIFO, CMD_SYNC});
    for (int k = 0; k < 9; k++) begin
      b[k] = 8'h1D * k[7:0] + 8'h42;
      apb(1'b1, OFF_TXDATA, {24'h0, b[k]});
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("full", 32'h1, {31'h0, rd[ST_FULL_BIT]});
    for (int k = 0; k < 9; k++) begin
      n = 0;
      rd = 32'h0;
      while (rd[ST_RXVALID_BIT] !== 1'b1 && n < 100) begin
        apb(1'b0, OFF_STATUS, 32'h0);
        n++;
      end
      chk("rx valid", 32'h1, {31'h0, rd[ST_RXVALID_BIT]});
      apb(1'b0, OFF_RXDATA, 32'h0);
      if (k > 0) begin
        chk("lagged pins", {24'h0, b[k-1]}, rd);
      end
    end
    repeat (50) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("sync idle", 32'h12, rd);
    chk("sync rd pair1", 32'h0, {31'h0, pair1_rd_n});
    chk("sync rd pair2", 32'h1, {31'h0, pair2_rd_n});
  endtask
  task automatic t_refuse;
    apb(1'b1, OFF_CTRL, {24'h0, 2'b01, IFM_FAST_OPTO, CMD_ASYNC});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("refused", 32'h4, {29'h0, rd[2:0]});
    chk("oe off", 32'h0, {24'h0, data_oe});
  endtask
  task automatic t_wake(input logic susp, input logic en, input logic [31:0] exp);
    power_enable_n <= susp;
    apb(1'b1, OFF_CTRL, {24'h0, en, 7'h0});
    send_now_wake_n <= 1'b0;
    repeat (2) @(posedge pclk);
    send_now_wake_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("wake flags", exp, {24'h0, rd[7:6], 6'h0});
  endtask
  // ==========
  // main sequence and watchdog
  initial begin
    #500000;
    n_errors++;
    test_done();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_val = 8'hFF;
    power_enable_n = 1'b0;
    send_now_wake_n = 1'b1;
    rx_avail_n = 1'b1;
    tx_space_n = 1'b1;
    n_errors = 0;
    checks = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    apb(1'b1, OFF_BAUD, 32'h3);
    t_async(IFM_UART, 8'h55, 8'hFF);
    t_async(IFM_FIFO, 8'hAA, 8'h0F);
    t_async(IFM_CPU_FIFO, 8'h3C, 8'hF0);
    t_async(IFM_FAST_OPTO, 8'hC3, 8'hFF);
    t_sync();
    t_refuse();
    t_wake(1'b1, 1'b1, 32'h40);
    t_wake(1'b1, 1'b0, 32'h0);
    t_wake(1'b0, 1'b1, 32'h80);
    test_done();
  end
endmodule
